/* autoneg_partner_cfg.svh */
// constants for the partner next-page and expansion status registers
`ifndef AUTONEG_PARTNER_CFG_SVH
`define AUTONEG_PARTNER_CFG_SVH

// register offsets on the management interface
`define PAGE_WORD_OFFSET 5'h05
`define EXP_STATUS_OFFSET 5'h06

// reset values, fixed read values and default address
`define PAGE_WORD_RESET 16'h0000
`define EXP_RESERVED_RESET 11'h000
`define LOCAL_NEXTPAGE_CAPABLE 1'h1
`define UNMAPPED_READ_VALUE 16'h0000
`define PHY_ADDR_DEFAULT 5'h01

// field positions of the incoming link code word
`define LCW_FURTHER_BIT 15
`define LCW_ACK_BIT 14
`define LCW_MSG_PAGE_BIT 13
`define LCW_COMPLY_BIT 12
`define LCW_CODE_MSB 10

// management frame layout, counted in management clock periods
`define PREAMBLE_BITS 6'h20
`define HEADER_BITS 4'hC
`define TURN_BITS 2'h2
`define DATA_BITS 5'h10
`define OP_READ 2'h2
`define OP_WRITE 2'h1

`endif

/* autoneg_pkg.sv */
// types shared by the auto-negotiation partner status registers
package autoneg_pkg;

	typedef struct packed {
		logic further_page_request;
		logic partner_ack;
		logic message_page_flag;
		logic partner_comply_ack;
		logic toggle;
		logic [10:0] code;
	} page_word_t;

	typedef struct packed {
		logic [10:0] reserved;
		logic parallel_detect_fault;
		logic partner_nextpage_capable;
		logic local_nextpage_capable;
		logic page_received;
		logic partner_autoneg_capable;
	} exp_status_t;

	typedef struct packed {
		logic [1:0] op;
		logic [4:0] phy;
		logic [4:0] reg_addr;
	} mgmt_header_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_HEADER = 3'b010,
		ST_TURN = 3'b011,
		ST_DATA = 3'b100
	} mgmt_state_t;

endpackage

/* autoneg_expansion_reg.sv */
// expansion status register with clear-on-read page flag
`timescale 1ns/1ps
`include "autoneg_partner_cfg.svh"

module autoneg_expansion_reg (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic parallel_detect_fault_in,
	input wire logic partner_nextpage_capable_in,
	input wire logic partner_autoneg_capable_in,
	input wire logic page_set_in,
	input wire logic read_clear_in,
	output autoneg_pkg::exp_status_t exp_status_out
);

	logic fault_flag;
	logic partner_nextpage_flag;
	logic partner_autoneg_flag;
	logic page_flag;

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fault_flag <= 1'b0;
		end else begin
			fault_flag <= parallel_detect_fault_in;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			partner_nextpage_flag <= 1'b0;
		end else begin
			partner_nextpage_flag <= partner_nextpage_capable_in;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			partner_autoneg_flag <= 1'b0;
		end else begin
			partner_autoneg_flag <= partner_autoneg_capable_in;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			page_flag <= 1'b0;
		end else if (page_set_in) begin
			page_flag <= 1'b1;
		end else if (read_clear_in) begin
			page_flag <= 1'b0;
		end
	end

	// local ability fixed one
	// one driver for the whole word; the fixed bits need no flip-flop
	assign exp_status_out = {`EXP_RESERVED_RESET, fault_flag, partner_nextpage_flag,
		`LOCAL_NEXTPAGE_CAPABLE, page_flag, partner_autoneg_flag};

	a_fault_follows: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		##1 exp_status_out.parallel_detect_fault == $past(parallel_detect_fault_in))
		else $error("fault flag does not follow detector");
	a_partner_nextpage: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		$rose(partner_nextpage_capable_in) |=> exp_status_out.partner_nextpage_capable)
		else $error("partner next page ability not reported");
	a_partner_an: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		$fell(partner_autoneg_capable_in) |=> !exp_status_out.partner_autoneg_capable)
		else $error("partner autoneg ability not cleared");
	a_local_ability_one: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		exp_status_out.local_nextpage_capable && exp_status_out.reserved == 11'h000)
		else $error("fixed bits of expansion status wrong");
	a_page_set: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		page_set_in |=> exp_status_out.page_received)
		else $error("page flag not set on received word");
	a_page_clear: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		read_clear_in && !page_set_in |=> !exp_status_out.page_received)
		else $error("page flag not cleared by read");
	a_page_hold: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		!read_clear_in && exp_status_out.page_received |=> exp_status_out.page_received)
		else $error("page flag lost without read");

endmodule

/* autoneg_partner_page_status.sv */
// partner next-page and expansion status registers behind the management interface
//
// Summary of operation
// - ack bit driven by negotiation logic only
// - message page flag read-only, resets zero
// - comply ack shows partner ability, resets zero
// - toggle reads inverse of previous transmitted toggle
// - 11-bit code read-only, resets all zeros
// - expansion bits 15:5 ignore writes, read zero
// - fault bit follows parallel detection fault
// - report partner next page support
// - local next page ability reads fixed one
// - page flag set on word, read clears
// - report partner autoneg support, resets zero
// - top bit shows partner wants another page
`timescale 1ns/1ps
`include "autoneg_partner_cfg.svh"

module autoneg_partner_page_status #(
	parameter logic [4:0] PHY_ADDR = `PHY_ADDR_DEFAULT
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic mdc_in,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_out,
	input wire logic lcw_strobe_in,
	input wire logic [15:0] lcw_word_in,
	input wire logic tx_toggle_in,
	input wire logic parallel_detect_fault_in,
	input wire logic partner_nextpage_capable_in,
	input wire logic partner_autoneg_capable_in
);

	autoneg_pkg::page_word_t page_word;
	autoneg_pkg::exp_status_t exp_status;
	autoneg_pkg::mgmt_state_t state;
	autoneg_pkg::mgmt_header_t next_header;
	logic mdc_prev;
	logic mdc_rise;
	logic [5:0] ones_cnt;
	logic [4:0] bit_cnt;
	logic [10:0] hdr_shift;
	logic [15:0] rd_shift;
	logic read_active;
	logic read_clear;
	logic header_done;
	logic read_hit;

	// management clock is sampled; bits are taken on its rising edge
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mdc_prev <= 1'b0;
		end else begin
			mdc_prev <= mdc_in;
		end
	end

	assign mdc_rise = mdc_in & ~mdc_prev;
	assign next_header = {hdr_shift, mdio_in};
	assign header_done = mdc_rise && state == autoneg_pkg::ST_HEADER &&
		bit_cnt == 5'(`HEADER_BITS - 4'h1);
	assign read_hit = next_header.op == `OP_READ && next_header.phy == PHY_ADDR;

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			page_word <= autoneg_pkg::page_word_t'(`PAGE_WORD_RESET);
		end else if (lcw_strobe_in) begin
			page_word.further_page_request <= lcw_word_in[`LCW_FURTHER_BIT];
			page_word.partner_ack <= lcw_word_in[`LCW_ACK_BIT];
			page_word.message_page_flag <= lcw_word_in[`LCW_MSG_PAGE_BIT];
			page_word.partner_comply_ack <= lcw_word_in[`LCW_COMPLY_BIT];
			page_word.toggle <= ~tx_toggle_in;
			page_word.code <= lcw_word_in[`LCW_CODE_MSB:0];
		end
	end

	autoneg_expansion_reg u_expansion (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.parallel_detect_fault_in(parallel_detect_fault_in),
		.partner_nextpage_capable_in(partner_nextpage_capable_in),
		.partner_autoneg_capable_in(partner_autoneg_capable_in),
		.page_set_in(lcw_strobe_in),
		.read_clear_in(read_clear),
		.exp_status_out(exp_status)
	);

	// frame sequencing; a fresh preamble is required before every frame
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= autoneg_pkg::ST_IDLE;
			ones_cnt <= 6'h00;
			bit_cnt <= 5'h00;
		end else if (mdc_rise) begin
			case (state)
				autoneg_pkg::ST_IDLE: begin
					bit_cnt <= 5'h00;
					if (mdio_in) begin
						if (ones_cnt != `PREAMBLE_BITS) begin
							ones_cnt <= ones_cnt + 6'h01;
						end
					end else begin
						ones_cnt <= 6'h00;
						if (ones_cnt == `PREAMBLE_BITS) begin
							state <= autoneg_pkg::ST_START;
						end
					end
				end
				autoneg_pkg::ST_START: begin
					state <= mdio_in ? autoneg_pkg::ST_HEADER : autoneg_pkg::ST_IDLE;
				end
				autoneg_pkg::ST_HEADER: begin
					if (header_done) begin
						state <= autoneg_pkg::ST_TURN;
						bit_cnt <= 5'h00;
					end else begin
						bit_cnt <= bit_cnt + 5'h01;
					end
				end
				autoneg_pkg::ST_TURN: begin
					if (bit_cnt == 5'(`TURN_BITS - 2'h1)) begin
						state <= autoneg_pkg::ST_DATA;
						bit_cnt <= 5'h00;
					end else begin
						bit_cnt <= bit_cnt + 5'h01;
					end
				end
				autoneg_pkg::ST_DATA: begin
					if (bit_cnt == 5'(`DATA_BITS - 5'h01)) begin
						state <= autoneg_pkg::ST_IDLE;
						bit_cnt <= 5'h00;
					end else begin
						bit_cnt <= bit_cnt + 5'h01;
					end
				end
				default: begin
					state <= autoneg_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hdr_shift <= 11'h000;
		end else if (mdc_rise && state == autoneg_pkg::ST_HEADER) begin
			hdr_shift <= next_header[10:0];
		end
	end

	// snapshot at end of header, clear only the expansion register
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			read_active <= 1'b0;
			read_clear <= 1'b0;
		end else begin
			read_clear <= header_done && read_hit &&
				next_header.reg_addr == `EXP_STATUS_OFFSET;
			if (header_done) begin
				read_active <= read_hit;
			end else if (mdc_rise && state == autoneg_pkg::ST_IDLE) begin
				read_active <= 1'b0;
			end
		end
	end

	// writes are never stored; only the read opcode is decoded
	// ack bit has no write path
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_shift <= 16'h0000;
		end else if (header_done) begin
			case (next_header.reg_addr)
				`PAGE_WORD_OFFSET: begin
					rd_shift <= page_word;
				end
				`EXP_STATUS_OFFSET: begin
					rd_shift <= exp_status;
				end
				default: begin
					rd_shift <= `UNMAPPED_READ_VALUE;
				end
			endcase
		end else if (mdc_rise && read_active &&
			(state == autoneg_pkg::ST_DATA ||
			(state == autoneg_pkg::ST_TURN && bit_cnt == 5'h01))) begin
			rd_shift <= {rd_shift[14:0], 1'b0};
		end
	end

	// drive changes just after the rising edge so the host samples a settled bit
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mdio_out <= 1'b0;
			mdio_oe_out <= 1'b0;
		end else if (mdc_rise) begin
			if (state == autoneg_pkg::ST_TURN && read_active) begin
				mdio_oe_out <= 1'b1;
				mdio_out <= (bit_cnt == 5'h01) ? rd_shift[15] : 1'b0;
			end else if (state == autoneg_pkg::ST_DATA && read_active &&
				bit_cnt != 5'(`DATA_BITS - 5'h01)) begin
				mdio_out <= rd_shift[15];
			end else begin
				mdio_oe_out <= 1'b0;
				mdio_out <= 1'b0;
			end
		end
	end

	sequence s_word_taken;
		lcw_strobe_in;
	endsequence

	sequence s_read_exp;
		header_done && read_hit && next_header.reg_addr == `EXP_STATUS_OFFSET;
	endsequence

	a_ack_follows: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		s_word_taken |=> page_word.partner_ack == $past(lcw_word_in[14]))
		else $error("ack bit not taken from received word");
	a_page_type: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		s_word_taken |=> page_word.message_page_flag == $past(lcw_word_in[13]))
		else $error("message page flag wrong");
	a_comply_ack: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		s_word_taken |=> page_word.partner_comply_ack == $past(lcw_word_in[12]))
		else $error("comply ack wrong");
	a_toggle_inverse: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		s_word_taken |=> page_word.toggle != $past(tx_toggle_in))
		else $error("toggle not inverse of transmitted toggle");
	a_code_stable: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		!lcw_strobe_in |=> $stable(page_word))
		else $error("next page word changed without received word");
	a_further_page: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		s_word_taken |=> page_word.further_page_request == $past(lcw_word_in[15]))
		else $error("further page request wrong");
	a_clear_on_read: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		read_clear |-> $past(header_done) && $past(next_header.reg_addr) == 5'h06)
		else $error("clear pulse without expansion read");
	a_read_clears: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		s_read_exp ##1 !lcw_strobe_in |=> !exp_status.page_received)
		else $error("expansion read did not clear page flag");
	a_turn_drive: assert property (
		@(posedge clock_in) disable iff (!reset_n_in)
		header_done && read_hit |-> ##[1:400] (mdio_oe_out && !mdio_out))
		else $error("no turnaround drive after read header");

endmodule

/* autoneg_mdio_host.sv */
// management host model that sends frames on the serial management wire
`timescale 1ns/1ps

module autoneg_mdio_host (
	input wire logic clock_in,
	input wire logic dev_out_in,
	input wire logic dev_oe_in,
	output logic mdc_out,
	output logic mdio_out
);
	logic drive;
	logic level;

	// a released wire reads high through its pull-up
	assign mdio_out = dev_oe_in ? dev_out_in : (drive ? level : 1'b1);

	initial begin
		mdc_out = 1'b0;
		drive = 1'b0;
		level = 1'b1;
	end

	task automatic frame(input int npre, input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] addr, input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] tail;
		tail = {2'b01, op, phy, addr, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 0; i < npre + 32; i++) begin
			@(posedge clock_in);
			mdc_out <= 1'b0;
			// a read hands the wire over from the first turnaround bit on
			drive <= !(op == 2'h2 && i >= npre + 14);
			level <= (i < npre) ? 1'b1 : tail[npre + 31 - i];
			@(posedge clock_in);
			@(posedge clock_in);
			mdc_out <= 1'b1;
			// sampled just before the rise, while the previous bit still stands
			if (i >= npre + 16)
				rd = {rd[14:0], mdio_out};
			@(posedge clock_in);
		end
		@(posedge clock_in);
		mdc_out <= 1'b0;
		drive <= 1'b0;
	endtask
endmodule

/* autoneg_partner_page_status_tb.sv */
// self-checking bench for the partner next-page and expansion status registers
`timescale 1ns/1ps
`include "autoneg_partner_cfg.svh"

module autoneg_partner_page_status_tb;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic mdc;
	logic mdio;
	logic dev_out;
	logic dev_oe;
	logic lcw_strobe = 1'b0;
	logic [15:0] lcw_word = 16'h0000;
	logic tx_toggle = 1'b0;
	logic fault = 1'b0;
	logic partner_nextpage = 1'b0;
	logic partner_an = 1'b0;
	logic [15:0] rd;
	int error_cnt = 0;
	int cmp_count = 0;

	always #10 clock_in = ~clock_in;

	autoneg_partner_page_status DUT (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.mdc_in(mdc),
		.mdio_in(mdio),
		.mdio_out(dev_out),
		.mdio_oe_out(dev_oe),
		.lcw_strobe_in(lcw_strobe),
		.lcw_word_in(lcw_word),
		.tx_toggle_in(tx_toggle),
		.parallel_detect_fault_in(fault),
		.partner_nextpage_capable_in(partner_nextpage),
		.partner_autoneg_capable_in(partner_an)
	);

	autoneg_mdio_host host (
		.clock_in(clock_in),
		.dev_out_in(dev_out),
		.dev_oe_in(dev_oe),
		.mdc_out(mdc),
		.mdio_out(mdio)
	);

	task automatic check16(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_reg(input logic [4:0] addr, input logic [15:0] exp);
		host.frame(32, `OP_READ, `PHY_ADDR_DEFAULT, addr, 16'h0000, rd);
		check16(rd, exp);
	endtask

	task automatic page(input logic [15:0] w, input logic tog);
		@(posedge clock_in);
		lcw_strobe <= 1'b1;
		lcw_word <= w;
		tx_toggle <= tog;
		@(posedge clock_in);
		lcw_strobe <= 1'b0;
	endtask

	task automatic test_reset();
		rd_reg(`PAGE_WORD_OFFSET, 16'h0000); // zero after reset
		rd_reg(`EXP_STATUS_OFFSET, 16'h0004); // only local bit
	endtask

	task automatic test_words();
		page(16'hA7FF, 1'b0);
		rd_reg(`PAGE_WORD_OFFSET, 16'hAFFF); // fields and toggle
		rd_reg(`EXP_STATUS_OFFSET, 16'h0006); // flag set
		rd_reg(`EXP_STATUS_OFFSET, 16'h0004); // flag cleared by read
		page(16'h5800, 1'b1);
		rd_reg(`PAGE_WORD_OFFSET, 16'h5000); // other values
	endtask

	task automatic test_status();
		logic [15:0] want;
		for (int k = 0; k < 3; k++) begin
			@(posedge clock_in);
			{fault, partner_nextpage, partner_an} <= 3'h4 >> k;
			// the first read still sees the page flag left by the last word
			want = k == 0 ? 16'h0016 : k == 1 ? 16'h000C : 16'h0005;
			rd_reg(`EXP_STATUS_OFFSET, want); // levels
		end
		@(posedge clock_in);
		partner_an <= 1'b0;
	endtask

	task automatic test_writes();
		page(16'h1234, 1'b0);
		host.frame(32, `OP_WRITE, `PHY_ADDR_DEFAULT, `PAGE_WORD_OFFSET, 16'hFFFF, rd);
		host.frame(32, `OP_WRITE, `PHY_ADDR_DEFAULT, `EXP_STATUS_OFFSET, 16'hFFFF, rd);
		rd_reg(`PAGE_WORD_OFFSET, 16'h1A34); // word kept
		rd_reg(`EXP_STATUS_OFFSET, 16'h0006); // reserved zero
	endtask

	task automatic test_refused();
		page(16'h0001, 1'b1);
		rd_reg(5'h07, 16'h0000); // unmapped reads zero
		host.frame(32, `OP_READ, 5'h02, `EXP_STATUS_OFFSET, 16'h0000, rd);
		check16(rd, 16'hFFFF); // other address stays silent
		host.frame(31, `OP_READ, `PHY_ADDR_DEFAULT, `EXP_STATUS_OFFSET, 16'h0000, rd);
		check16(rd, 16'hFFFF); // short preamble ignored
		rd_reg(`EXP_STATUS_OFFSET, 16'h0006); // flag survived
	endtask

	task automatic give_verdict();
		$display("comparisons %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// about seventeen frames of some 260 cycles each are expected
	initial begin
		repeat (20000) @(posedge clock_in);
		error_cnt++;
		give_verdict();
	end

	initial begin
		repeat (16) @(posedge clock_in);
		reset_n_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		test_reset();
		test_words();
		test_status();
		test_writes();
		test_refused();
		give_verdict();
	end
endmodule
